// ==== src/sfa_alias.sv ====
// shared simd / floating-point register file with tag and top tracking
// assumes decode presents one classified instruction per valid cycle
//
`default_nettype none
module sfa_alias (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // system control flags
  input wire logic I_EMULATION_FLAG,
  input wire logic I_TASK_SWITCHED_FLAG,
  input wire logic I_FP_EXC_PENDING,
  // instruction port
  input wire sfa_pkg::sfa_req_t I_REQ,
  // answers and visible state
  output sfa_pkg::sfa_rsp_t O_RSP,
  output logic [15:0] O_TAG_WORD,
  output logic [15:0] O_STATUS_WORD,
  output logic [7:0] O_INT
);
  import sfa_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // classify a register value into a tag for the saved image
  function automatic logic [1:0] value_tag(input logic [FP_W-1:0] v);
    if (v[FP_W-2:MANT_W] == EXP_MAX) begin
      value_tag = TAG_SPECIAL;
    end else if (v[FP_W-2:0] == '0) begin
      value_tag = TAG_ZERO;
    end else if (v[FP_W-2:MANT_W] == 15'h0000 || !v[MANT_W-1]) begin
      value_tag = TAG_SPECIAL;
    end else begin
      value_tag = TAG_VALID;
    end
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [FP_W-1:0] fp_reg_r [NUM_REGS];
  logic [15:0] tag_r;
  logic [15:0] status_r;
  sfa_rsp_t rsp_r;
  logic [7:0] int_r;

  logic is_simd;
  logic go_ud;
  logic go_nm;
  logic go_mf;
  logic exec;

  // ---------------------------------------------------------------
  // fault gating
  // ---------------------------------------------------------------
  always_comb begin
    is_simd = I_REQ.valid && (I_REQ.op == SFA_OP_SIMD_RD || I_REQ.op == SFA_OP_SIMD_WR ||
              I_REQ.op == SFA_OP_SIMD_CLR);
    go_ud = is_simd && I_EMULATION_FLAG;
    go_nm = is_simd && !I_EMULATION_FLAG && I_TASK_SWITCHED_FLAG;
    go_mf = is_simd && !go_ud && !go_nm && I_FP_EXC_PENDING;
    exec = I_REQ.valid && !go_ud && !go_nm && !go_mf;
  end

  // ---------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        fp_reg_r[i] <= '0;
      end
    end else if (exec) begin
      // index is physical, never offset by top
      if (I_REQ.op == SFA_OP_SIMD_WR) begin
        fp_reg_r[I_REQ.reg_idx] <= {EXP_ONES, I_REQ.data[MANT_W-1:0]};
      end else if (I_REQ.op == SFA_OP_FP && I_REQ.fp_wr && !I_REQ.fp_empty) begin
        fp_reg_r[I_REQ.reg_idx] <= I_REQ.data;
      end
      // simd reads and clear leave every data register alone
    end
  end

  // ---------------------------------------------------------------
  // tag word
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      tag_r <= TAG_WORD_RST;
    end else if (exec) begin
      case (I_REQ.op)
        SFA_OP_SIMD_RD, SFA_OP_SIMD_WR: begin
          tag_r <= {NUM_REGS{TAG_VALID}};
        end
        SFA_OP_SIMD_CLR: begin
          tag_r <= {NUM_REGS{TAG_EMPTY}};
        end
        SFA_OP_FP: begin
          if (I_REQ.fp_wr) begin
            tag_r[I_REQ.reg_idx*2 +: 2] <= I_REQ.fp_empty ? TAG_EMPTY : TAG_VALID;
          end
        end
        SFA_OP_SAVE: begin
          tag_r <= {NUM_REGS{TAG_EMPTY}};
        end
        SFA_OP_RESTORE: begin
          for (int i = 0; i < NUM_REGS; i++) begin
            tag_r[i*2 +: 2] <= (I_REQ.image_tags[i*2 +: 2] == TAG_EMPTY) ?
                               TAG_EMPTY : value_tag(fp_reg_r[i]);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status word: only the top field is touched by simd
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      status_r <= STATUS_RST;
    end else if (exec) begin
      if (is_simd) begin
        status_r[TOP_MSB:TOP_LSB] <= TOP_CLEAR;
      end else if (I_REQ.op == SFA_OP_FP && I_REQ.top_wr) begin
        status_r[TOP_MSB:TOP_LSB] <= I_REQ.top_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // answers
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      rsp_r <= '0;
    end else begin
      rsp_r.done <= exec;
      rsp_r.fault_ud <= go_ud;
      rsp_r.fault_nm <= go_nm;
      rsp_r.fault_mf <= go_mf;
      rsp_r.image_tags <= I_REQ.image_tags;
      if (exec && I_REQ.op == SFA_OP_SAVE) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          rsp_r.image_tags[i*2 +: 2] <= (tag_r[i*2 +: 2] == TAG_EMPTY) ?
                                        TAG_EMPTY : value_tag(fp_reg_r[i]);
        end
      end
      // tag word plays no part in simd reads
      rsp_r.rd_data <= fp_reg_r[I_REQ.reg_idx][MANT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // event flags
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      int_r <= '0;
    end else begin
      int_r <= {5'h00, go_mf, go_nm, go_ud};
    end
  end

  assign O_RSP = rsp_r;
  assign O_TAG_WORD = tag_r;
  assign O_STATUS_WORD = status_r;
  assign O_INT = int_r;
endmodule
`default_nettype wire

// ==== common/sfa_pkg.sv ====
// shared constants and carrier types of the simd/fp register alias block
// assumes one core clock, decode pipeline classifies every instruction
// What this block does
// - emulation flag set: invalid-opcode fault always
// - task-switched set: device-unavailable fault, else pending fp exception check, then execute
// - eight simd registers live in fp low bits
// - simd n maps physical n, ignores top
// - fp writes visible through aliased simd register
// - simd write forces bits 64..79 to ones
// - simd instructions except clear set tags valid
// - clear-simd-state sets all tags empty
// - every simd instruction zeroes top-of-stack field
// - simd leaves other status and fp registers
// - simd reads and clear keep data registers
// - tag word never affects simd behaviour
// - saves compute real tags, then empty all
// - ordinary fp sets modified tag 00/11
// - restores keep empty tags, derive the rest
// - pending fp exception faults before simd executes
`default_nettype none
package sfa_pkg;
  localparam int NUM_REGS = 8;
  localparam int MANT_W = 64;
  localparam int FP_W = 80;
  localparam int TOP_LSB = 11;
  localparam int TOP_MSB = 13;
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_ZERO = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  localparam logic [15:0] TAG_WORD_RST = 16'hFFFF;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [2:0] TOP_CLEAR = 3'h0;
  localparam logic [15:0] EXP_ONES = 16'hFFFF;
  localparam logic [14:0] EXP_MAX = 15'h7FFF;

  typedef enum logic [2:0] {
    SFA_OP_NONE,
    SFA_OP_SIMD_RD,
    SFA_OP_SIMD_WR,
    SFA_OP_SIMD_CLR,
    SFA_OP_FP,
    SFA_OP_SAVE,
    SFA_OP_RESTORE
  } sfa_op_t;

  // one instruction presented by the decode pipeline
  typedef struct packed {
    logic valid;
    sfa_op_t op;
    logic [2:0] reg_idx;
    logic [FP_W-1:0] data;
    logic fp_wr;
    logic fp_empty;
    logic top_wr;
    logic [2:0] top_val;
    logic [15:0] image_tags;
  } sfa_req_t;

  // answer of one instruction, one cycle later
  typedef struct packed {
    logic done;
    logic fault_ud;
    logic fault_nm;
    logic fault_mf;
    logic [15:0] image_tags;
    logic [MANT_W-1:0] rd_data;
  } sfa_rsp_t;
endpackage
`default_nettype wire

// ==== sim/sfa_decode_model.sv ====
// decode pipeline model presenting classified instructions
// assumes the bench calls it just after a rising edge
`default_nettype none
module sfa_decode_model (
  // instruction port toward the alias block
  output var sfa_pkg::sfa_req_t o_req
);
  import sfa_pkg::*;
  initial o_req = '0;
  task automatic put(input sfa_req_t r);
    o_req <= r;
  endtask
  // released port: valid low, payload turned over
  task automatic idle();
    o_req.valid <= 1'b0;
    o_req.data <= ~o_req.data;
  endtask
endmodule
`default_nettype wire

// ==== sim/sfa_alias_monitor.sv ====
// checker on the alias block ports
// assumes a bind from the bench top
`default_nettype none
module sfa_monitor (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_EMULATION_FLAG,
  input wire logic I_TASK_SWITCHED_FLAG,
  input wire logic I_FP_EXC_PENDING,
  input wire sfa_pkg::sfa_req_t I_REQ,
  input wire sfa_pkg::sfa_rsp_t O_RSP,
  input wire logic [15:0] O_TAG_WORD,
  input wire logic [15:0] O_STATUS_WORD
);
  import sfa_pkg::*;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  logic s, e, t, ok;
  assign s = I_REQ.valid && I_REQ.op inside {SFA_OP_SIMD_RD, SFA_OP_SIMD_WR, SFA_OP_SIMD_CLR};
  assign e = s && I_EMULATION_FLAG;
  assign t = s && !I_EMULATION_FLAG && I_TASK_SWITCHED_FLAG;
  assign ok = s && !I_EMULATION_FLAG && !I_TASK_SWITCHED_FLAG && !I_FP_EXC_PENDING;
  sequence s_wr_rd;
    ok && I_REQ.op == SFA_OP_SIMD_WR ##1 ok && I_REQ.reg_idx == $past(I_REQ.reg_idx);
  endsequence
  chk_em_ud: assert property (e |=> O_RSP.fault_ud && !O_RSP.done) else $error("ud");
  chk_ts_nm: assert property (t |=> O_RSP.fault_nm && !O_RSP.done) else $error("nm");
  chk_pend_mf: assert property (s && !e && !t && !ok |=> O_RSP.fault_mf && $stable(O_TAG_WORD))
    else $error("mf");
  chk_top_zero: assert property (ok |=> O_STATUS_WORD[13:11] == TOP_CLEAR) else $error("top");
  chk_st_keep: assert property (ok |=> (O_STATUS_WORD & 16'hC7FF) == ($past(O_STATUS_WORD) & 16'hC7FF))
    else $error("st");
  chk_tag_valid: assert property (ok && I_REQ.op != SFA_OP_SIMD_CLR |=> O_TAG_WORD == 16'h0000)
    else $error("tag");
  chk_tag_empty: assert property (ok && I_REQ.op == SFA_OP_SIMD_CLR |=> O_TAG_WORD == TAG_WORD_RST)
    else $error("clr");
  chk_wr_rd: assert property (s_wr_rd |=> O_RSP.rd_data == $past(I_REQ.data[63:0], 2)) else $error("rd");
endmodule
`default_nettype wire

// ==== sim/sfa_alias_bench.sv ====
// self-checking bench for sfa_alias with the decode model
// assumes a 40 MHz clock; answers are checked in issue order
`default_nettype none
module sfa_alias_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sfa_pkg::*;
  logic clk = 0, rst_n = 0, em = 0, ts = 0, pend = 0;
  logic [15:0] tag, st, mtag = 16'hFFFF;
  logic [2:0] top = 3'h0;
  logic [79:0] mem[8] = '{default: '0};
  logic [110:0] q[$];
  logic [7:0] irq;
  int miscompares, total_checks;
  sfa_req_t req;
  sfa_rsp_t rsp;
  always #12.5 clk = ~clk;
  sfa_decode_model drv (.o_req(req));
  sfa_alias uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_EMULATION_FLAG(em), .I_TASK_SWITCHED_FLAG(ts),
    .I_FP_EXC_PENDING(pend), .I_REQ(req), .O_RSP(rsp), .O_TAG_WORD(tag), .O_STATUS_WORD(st), .O_INT(irq));
  task automatic check(input logic [110:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // notes the expected answer, then presents the instruction
  task automatic go(input sfa_op_t o, input logic [2:0] i, input logic [15:0] et = 16'h0,
      input logic [2:0] f = 3'h0, input logic [15:0] img = 16'h0);
    logic [79:0] d;
    logic s, ud, nm, mf, k;
    d = {16'h3FFF, 1'b1, 31'($urandom), $urandom};
    s = o inside {SFA_OP_SIMD_RD, SFA_OP_SIMD_WR, SFA_OP_SIMD_CLR};
    ud = s & f[2];
    nm = s & !f[2] & f[1];
    mf = s & !f[2] & !f[1] & f[0];
    k = ud | nm | mf;
    if (!k) mtag = et;
    if (!k) top = s ? 3'h0 : (o == SFA_OP_FP ? 3'h5 : top);
    // a save image marks every simd-written register special
    q.push_back({!k, ud, nm, mf, (o == SFA_OP_SAVE ? 16'hAAAA : img), mem[i][63:0], mtag, top,
      5'h00, mf, nm, ud});
    if (o == SFA_OP_FP) mem[i] = d;
    if (o == SFA_OP_SIMD_WR && !k) mem[i] = {EXP_ONES, d[63:0]};
    @(posedge clk);
    {em, ts, pend} <= f;
    drv.put('{1'b1, o, i, d, o == SFA_OP_FP, 1'b0, o == SFA_OP_FP, 3'h5, img});
  endtask
  always @(posedge clk)
    if ((rsp.done | rsp.fault_ud | rsp.fault_nm | rsp.fault_mf) === 1'b1)
      check({rsp, tag, st[13:11], irq}, q.size() > 0 ? q.pop_front() : '1);
  initial begin
    void'($urandom(32'h1cea));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // flag table assumes software keeps the monitor-coprocessor flag set
    for (int f = 0; f < 8; f++) go(SFA_OP_SIMD_WR, 3'h0, 16'h0, 3'(f));
    for (int i = 0; i < 8; i++) go(SFA_OP_SIMD_WR, 3'(i));
    for (int i = 7; i >= 0; i--) go(SFA_OP_SIMD_RD, 3'(i));
    go(SFA_OP_SAVE, 3'h0, 16'hFFFF);
    go(SFA_OP_RESTORE, 3'h0, 16'hAAFF, 3'h0, 16'h00FF);
    go(SFA_OP_FP, 3'h2, 16'hAACF, 3'h1, 16'h00FF);
    go(SFA_OP_SIMD_RD, 3'h2);
    go(SFA_OP_SIMD_CLR, 3'h5, 16'hFFFF);
    go(SFA_OP_SIMD_RD, 3'h5);
    @(posedge clk);
    drv.idle();
    for (int n = 0; n < 20 && q.size() > 0; n++) @(posedge clk);
    if (q.size() > 0) miscompares++;
    close_out();
  end
endmodule
bind sfa_alias sfa_monitor mon (.I_REF_CLK, .I_RST_N, .I_EMULATION_FLAG, .I_TASK_SWITCHED_FLAG,
  .I_FP_EXC_PENDING, .I_REQ, .O_RSP, .O_TAG_WORD, .O_STATUS_WORD);
`default_nettype wire
